// ### src/sent_slot_pkg.sv
// Package: register map, field layout, timing and carrier types of the shared SENT slot control
package sent_slot_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CFG_ID = 10'h308;
    localparam logic [9:0] IDX_CFG_SAMPLE = 10'h319;
    localparam logic [9:0] IDX_CTRL = 10'h320;
    localparam logic [9:0] IDX_STATUS = 10'h321;

    // Field positions
    localparam int HIGHEST_ID_LSB = 16;
    localparam int SUPPRESS_BIT = 11;
    localparam int ADDRESSING_BIT = 8;
    localparam int IDLE_RESYNC_BIT = 23;
    localparam int SYNC_SLOT_MODE_BIT = 0;
    localparam int OWN_ID_LSB = 8;
    localparam int TICK_LSB = 16;

    // Reset values
    localparam logic [1:0] HIGHEST_ID_RESET = 2'h0;
    localparam logic SUPPRESS_RESET = 1'b0;
    localparam logic ADDRESSING_RESET = 1'b0;
    localparam logic IDLE_RESYNC_RESET = 1'b0;
    localparam logic SYNC_SLOT_MODE_RESET = 1'b0;
    localparam logic [1:0] OWN_ID_RESET = 2'h0;

    // Timing: tick time and clock period in ns, cycles per tick derived
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS = 3000;
    localparam logic [15:0] TICK_CYCLES_RESET = 16'(TICK_TIME_NS / CLK_PERIOD_NS);
    localparam logic [9:0] IDLE_LIMIT_TICKS = 10'd510;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    // Answer back to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Function-pulse event from the pulse decoder
    typedef struct packed {
        logic sample_req;
        logic [1:0] target_id;
        logic slot_advance;
    } pulse_evt_t;

endpackage : sent_slot_pkg

// ### src/shared_sent_slot_sample_control.sv
// Top module: sample-request and idle slot-resync control of a sensor on a shared SENT line
// Notes on behaviour
// R1: The highest sensor id on the line comes from a two-bit field, codes 0..3 meaning one to four sensors.
// R2: With sample suppression clear a sample request causes a sample and hold, with it set requests are ignored.
// R3: With addressing clear every sample request is a broadcast that samples, unless suppressed.
// R4: With addressing set only a request aimed at this sensor samples, unless suppressed. The code also drops a target above the highest id.
// R5: With idle resync set the slot counter goes to zero once the line has been idle for more than 510 ticks.
// R6: With idle resync clear an idle line has no effect at all.
// R7: All sensors on one line should be given the same idle resync setting by the integrator.
// R8: The idle-triggered slot reset only applies in the synchronized-slot SENT mode.
// R9: Idle time is counted in ticks, restarted by any line edge, and the reset fires once per idle period.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module shared_sent_slot_sample_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire sent_slot_pkg::wb_req_t wb_req_i,
    output sent_slot_pkg::wb_rsp_t wb_rsp_o,
    // SENT line level from the pin
    input wire logic sent_line_i,
    // Decoded function pulses, same clock
    input wire sent_slot_pkg::pulse_evt_t pulse_i,
    // Results
    output logic sample_hold_o,
    output logic slot_reset_o,
    output logic [1:0] slot_count_o,
    output logic [1:0] highest_sensor_id_o
);

    typedef struct packed {
        sent_slot_pkg::wb_rsp_t rsp;
        logic [1:0] highest_sensor_id;
        logic sample_suppress;
        logic sample_pulse_addressing;
        logic idle_slot_resync;
        logic synchronized_slot_sent_mode;
        logic [1:0] own_id;
        logic [15:0] tick_cycles;
        logic line_meta;
        logic line_sync;
        logic line_prev;
        logic [15:0] prescale;
        logic [9:0] idle_ticks;
        logic idle_fired;
        logic [1:0] slot_count;
        logic [7:0] sample_count;
        logic sample_hold;
        logic slot_reset;
    } state_t;

    state_t cur;
    state_t next_state;

    // Merge write data into a register under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] cfg_id_word;
    logic [31:0] cfg_sample_word;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    // Register images as software sees them; reserved bits read zero
    // Keeping the images in one place means reads and merged writes agree bit for bit
    always_comb begin
        cfg_id_word = 32'h0;
        cfg_id_word[sent_slot_pkg::HIGHEST_ID_LSB +: 2] = cur.highest_sensor_id;
        cfg_sample_word = 32'h0;
        cfg_sample_word[sent_slot_pkg::SUPPRESS_BIT] = cur.sample_suppress;
        cfg_sample_word[sent_slot_pkg::ADDRESSING_BIT] = cur.sample_pulse_addressing;
        cfg_sample_word[sent_slot_pkg::IDLE_RESYNC_BIT] = cur.idle_slot_resync;
        ctrl_word = 32'h0;
        ctrl_word[sent_slot_pkg::SYNC_SLOT_MODE_BIT] = cur.synchronized_slot_sent_mode;
        ctrl_word[sent_slot_pkg::OWN_ID_LSB +: 2] = cur.own_id;
        ctrl_word[sent_slot_pkg::TICK_LSB +: 16] = cur.tick_cycles;
        status_word = {8'h0, cur.sample_count, 1'b0, cur.idle_fired, 1'b0, cur.line_sync, cur.slot_count, cur.idle_ticks};
    end

    logic bus_hit;
    logic tick;
    logic line_edge;
    logic addressed;
    logic do_sample;
    logic idle_expired;
    logic [9:0] index;
    logic [31:0] wr_word;

    // Next-state logic for the whole block
    always_comb begin
        next_state = cur;
        index = wb_req_i.adr[11:2];
        wr_word = 32'h0;
        bus_hit = wb_req_i.cyc && wb_req_i.stb && !cur.rsp.ack;

        // Bus slave: one-cycle ack, dropped in the following cycle
        // A held stb is taken again once ack drops, so masters must release right after ack
        next_state.rsp.ack = bus_hit;
        next_state.rsp.dat = 32'h0;
        if (bus_hit) begin
            unique case (index)
                sent_slot_pkg::IDX_CFG_ID: next_state.rsp.dat = cfg_id_word;
                sent_slot_pkg::IDX_CFG_SAMPLE: next_state.rsp.dat = cfg_sample_word;
                sent_slot_pkg::IDX_CTRL: next_state.rsp.dat = ctrl_word;
                sent_slot_pkg::IDX_STATUS: next_state.rsp.dat = status_word;
                default: next_state.rsp.dat = 32'h0; // Unmapped: acked, reads zero, writes dropped
            endcase
        end
        if (bus_hit && wb_req_i.we) begin
            unique case (index)
                sent_slot_pkg::IDX_CFG_ID: begin
                    wr_word = merge(cfg_id_word, wb_req_i.dat, wb_req_i.sel);
                    next_state.highest_sensor_id = wr_word[sent_slot_pkg::HIGHEST_ID_LSB +: 2]; // R1
                end
                sent_slot_pkg::IDX_CFG_SAMPLE: begin
                    wr_word = merge(cfg_sample_word, wb_req_i.dat, wb_req_i.sel);
                    next_state.sample_suppress = wr_word[sent_slot_pkg::SUPPRESS_BIT];
                    next_state.sample_pulse_addressing = wr_word[sent_slot_pkg::ADDRESSING_BIT];
                    next_state.idle_slot_resync = wr_word[sent_slot_pkg::IDLE_RESYNC_BIT];
                end
                sent_slot_pkg::IDX_CTRL: begin
                    wr_word = merge(ctrl_word, wb_req_i.dat, wb_req_i.sel);
                    next_state.synchronized_slot_sent_mode = wr_word[sent_slot_pkg::SYNC_SLOT_MODE_BIT];
                    next_state.own_id = wr_word[sent_slot_pkg::OWN_ID_LSB +: 2];
                    // A zero period would wrap the compare to the longest tick, so it is forced to one
                    next_state.tick_cycles = (wr_word[sent_slot_pkg::TICK_LSB +: 16] == 16'h0) ?
                        16'h1 : wr_word[sent_slot_pkg::TICK_LSB +: 16];
                end
                default: wr_word = 32'h0;
            endcase
        end

        // Pin synchroniser; only the second stage and its delayed copy are looked at
        next_state.line_meta = sent_line_i;
        next_state.line_sync = cur.line_meta;
        next_state.line_prev = cur.line_sync;
        line_edge = cur.line_sync != cur.line_prev;

        // Tick prescaler, realigned by line activity
        // Realigning on edges ties the tick phase to the line, as a receiver on the bus would
        tick = cur.prescale >= (cur.tick_cycles - 16'h1);
        if (line_edge || tick) begin
            next_state.prescale = 16'h0;
        end else begin
            next_state.prescale = cur.prescale + 16'h1;
        end

        // Idle tick counter, restarted by any edge and saturating past the limit
        // Saturation keeps a very long idle from wrapping back under the limit and firing again
        idle_expired = cur.idle_ticks > sent_slot_pkg::IDLE_LIMIT_TICKS; // R5
        if (line_edge) begin
            next_state.idle_ticks = 10'h0; // R9
            next_state.idle_fired = 1'b0;
        end else if (tick && !idle_expired) begin
            next_state.idle_ticks = cur.idle_ticks + 10'h1;
        end

        // Sample decision: suppression wins, then addressing filters
        // A target above the highest id cannot be this sensor, even with a misset own id
        addressed = (pulse_i.target_id == cur.own_id) && (pulse_i.target_id <= cur.highest_sensor_id); // R4
        do_sample = pulse_i.sample_req && !cur.sample_suppress && // R2
            (!cur.sample_pulse_addressing || addressed); // R3
        next_state.sample_hold = do_sample;
        if (do_sample) begin
            next_state.sample_count = cur.sample_count + 8'h1;
        end

        // Slot counter: advances per slot and wraps past the highest id on the line
        next_state.slot_reset = 1'b0;
        if (pulse_i.slot_advance) begin
            next_state.slot_count = (cur.slot_count >= cur.highest_sensor_id) ? 2'h0 : cur.slot_count + 2'h1; // R1
        end
        // Idle resync fires once per idle period, only in synchronized-slot mode
        // An edge in the cycle of expiry still lets the resync through: the line was idle long enough
        if (idle_expired && !cur.idle_fired) begin
            if (!line_edge) begin
                next_state.idle_fired = 1'b1; // R9
            end
            if (cur.idle_slot_resync && cur.synchronized_slot_sent_mode) begin // R6 R8
                next_state.slot_count = 2'h0; // R5
                next_state.slot_reset = 1'b1;
            end
        end

        if (rst_i) begin
            next_state = '0;
            next_state.highest_sensor_id = sent_slot_pkg::HIGHEST_ID_RESET;
            next_state.sample_suppress = sent_slot_pkg::SUPPRESS_RESET;
            next_state.sample_pulse_addressing = sent_slot_pkg::ADDRESSING_RESET;
            next_state.idle_slot_resync = sent_slot_pkg::IDLE_RESYNC_RESET;
            next_state.synchronized_slot_sent_mode = sent_slot_pkg::SYNC_SLOT_MODE_RESET;
            next_state.own_id = sent_slot_pkg::OWN_ID_RESET;
            next_state.tick_cycles = sent_slot_pkg::TICK_CYCLES_RESET;
            // Synchroniser starts at the idle high level so a quiet line gives no false edge
            next_state.line_meta = 1'b1;
            next_state.line_sync = 1'b1;
            next_state.line_prev = 1'b1;
        end
    end

    // Single state register, synchronous reset folded into next_state
    always_ff @(posedge clk_i) begin
        cur <= next_state;
    end

    // Outputs straight from flip-flops
    assign wb_rsp_o = cur.rsp;
    assign sample_hold_o = cur.sample_hold;
    assign slot_reset_o = cur.slot_reset;
    assign slot_count_o = cur.slot_count;
    assign highest_sensor_id_o = cur.highest_sensor_id;

endmodule // shared_sent_slot_sample_control

`default_nettype wire

// ### test/sent_slot_ctrl_assertions.sv
// Checker of the slot sample control ports
`timescale 1ns/1ps
`default_nettype none
module sent_slot_ctrl_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire sent_slot_pkg::wb_req_t wb_req_i,
    input wire sent_slot_pkg::wb_rsp_t wb_rsp_o,
    input wire logic sent_line_i,
    input wire sent_slot_pkg::pulse_evt_t pulse_i,
    input wire logic sample_hold_o,
    input wire logic slot_reset_o,
    input wire logic [1:0] slot_count_o,
    input wire logic [1:0] highest_sensor_id_o
);
    logic last_line;
    logic [9:0] quiet;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since the pin last moved; the design sees it later, so this is a floor
    always_ff @(posedge clk_i) begin
        last_line <= sent_line_i;
        if (rst_i || sent_line_i != last_line) quiet <= 10'h0;
        else if (quiet != 10'h3FF) quiet <= quiet + 10'h1;
    end
    chk_sample_cause: assert property (sample_hold_o |-> $past(pulse_i.sample_req))
        else $error("sample hold without request");
    chk_ack_latency: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("bus request not answered");
    chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held too long");
    chk_id_write: assert property ($changed(highest_sensor_id_o) |-> wb_rsp_o.ack && wb_req_i.we)
        else $error("highest id moved without write");
    chk_reset_zero: assert property (slot_reset_o |-> slot_count_o == 2'h0)
        else $error("slot not zero on resync");
    chk_reset_once: assert property (slot_reset_o |=> !slot_reset_o)
        else $error("resync fired twice");
    chk_idle_quiet: assert property (slot_reset_o |-> $past(quiet, 3) > 10'd510)
        else $error("resync before idle limit");
    chk_slot_cause: assert property ($changed(slot_count_o) |-> $past(pulse_i.slot_advance) || slot_reset_o)
        else $error("slot moved without cause");
endmodule // sent_slot_ctrl_checker
bind shared_sent_slot_sample_control sent_slot_ctrl_checker sent_slot_ctrl_checker_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .sent_line_i(sent_line_i), .pulse_i(pulse_i),
    .sample_hold_o(sample_hold_o), .slot_reset_o(slot_reset_o), .slot_count_o(slot_count_o),
    .highest_sensor_id_o(highest_sensor_id_o));
`default_nettype wire

// ### test/sent_ctrl_model.sv
// Bus controller model: line activity and function pulses
`timescale 1ns/1ps
`default_nettype none
module sent_ctrl_model (
    // Clock, reset, commands
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic act_i,
    input wire sent_slot_pkg::pulse_evt_t cmd_i,
    // Toward the sensor
    output logic line_o,
    output sent_slot_pkg::pulse_evt_t pulse_o
);
    // Pulses pass as commanded, launched just after an edge
    assign pulse_o = cmd_i;
    // Line toggles while busy; idle rests high as the pull-up leaves it
    always_ff @(posedge clk_i) begin
        if (rst_i || !act_i) line_o <= 1'b1;
        else line_o <= !line_o;
    end
endmodule // sent_ctrl_model
`default_nettype wire

// ### test/shared_sent_slot_sample_control_tb.sv
// Testbench of the shared SENT slot sample control
`timescale 1ns/1ps
`default_nettype none
module shared_sent_slot_sample_control_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic act = 1'b0;
    logic line, sh, sr;
    logic [1:0] sc_o, hid_o, hid, sc;
    logic [15:0] rnd = 16'hA236;
    logic [31:0] q;
    int err_total = 0, compares = 0, cyc_n = 0, n, hits = 0;
    sent_slot_pkg::wb_req_t wreq = '0;
    sent_slot_pkg::wb_rsp_t wrsp;
    sent_slot_pkg::pulse_evt_t cmd = '0, pls;
    // Clock and hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 30000) begin err_total++; close_out; end
    end
    sent_ctrl_model sent_ctrl_model_inst (.clk_i(clk_i), .rst_i(rst_i), .act_i(act), .cmd_i(cmd),
        .line_o(line), .pulse_o(pls));
    shared_sent_slot_sample_control shared_sent_slot_sample_control_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(wreq), .wb_rsp_o(wrsp), .sent_line_i(line), .pulse_i(pls), .sample_hold_o(sh),
        .slot_reset_o(sr), .slot_count_o(sc_o), .highest_sensor_id_o(hid_o));
    // Random source and expected sampling, own id fixed at 1
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic exp_s(input logic sup, input logic adr, input logic [1:0] t, input logic [1:0] h);
        return !sup && (!adr || (t == 2'h1 && t <= h));
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin err_total++; $display("unexpected at %0t: %h not %h", $time, seen, exp); end
    endtask
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        wreq <= '{1'b1, 1'b1, we, 4'hF, a, d};
        do @(posedge clk_i); while (wrsp.ack !== 1'b1);
        q = wrsp.dat;
        wreq <= '0;
        @(posedge clk_i);
    endtask
    // One function pulse; outputs looked at mid-cycle after it is taken
    task automatic pulse(input logic s, input logic [1:0] t, input logic a, input logic e);
        cmd <= '{s, t, a};
        @(posedge clk_i);
        cmd <= '0;
        @(negedge clk_i);
        check(sh, e);
        if (a) sc = (sc >= hid) ? 2'h0 : sc + 2'h1;
        check(sc_o, sc);
        @(posedge clk_i);
    endtask
    task automatic close_out;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sc = 2'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, then an unmapped place that reads zero
        wb(0, 12'hC20, 0); check(q, 0);
        wb(0, 12'hC64, 0); check(q, 0);
        wb(1, 12'hC10, 32'hFFFFFFFF); wb(0, 12'hC10, 0); check(q, 0);
        // Every highest id code at the port and read back
        for (int i = 0; i < 4; i++) begin
            wb(1, 12'hC20, 32'(i) << 16); wb(0, 12'hC20, 0);
            check(q, 32'(i) << 16);
            check(hid_o, i);
        end
        wb(1, 12'hC80, 32'h00010100);
        // Each suppress and addressing pair, random target and highest id
        for (int m = 0; m < 32; m++) begin
            rnd = lfsr(rnd);
            hid = rnd[3:2];
            wb(1, 12'hC20, {14'h0, hid, 16'h0});
            wb(1, 12'hC64, {20'h0, m[1], 2'h0, m[0], 8'h0});
            if (exp_s(m[1], m[0], rnd[1:0], hid)) hits++;
            pulse(1'b1, rnd[1:0], 1'b0, exp_s(m[1], m[0], rnd[1:0], hid));
        end
        // Status: samples taken so far and the current slot
        wb(0, 12'hC84, 0);
        check(q[23:16], hits[7:0]);
        check(q[11:10], sc);
        hid = 2'h3;
        wb(1, 12'hC20, 32'h00030000);
        // Idle with resync and mode on, resync off, mode off
        for (int k = 0; k < 3; k++) begin
            wb(1, 12'hC64, {8'h0, k != 1, 23'h0});
            wb(1, 12'hC80, {16'h1, 6'h0, 2'h1, 7'h0, k != 2});
            act <= 1'b1;
            pulse(1'b0, 2'h0, 1'b1, 1'b0);
            repeat (20) @(posedge clk_i);
            act <= 1'b0;
            n = 0;
            while (sr !== 1'b1 && n < 900) begin @(posedge clk_i); n++; end
            check(sr, k == 0);
            if (k == 0) begin check(n > 510, 1); sc = 2'h0; end
            check(sc_o, sc);
        end
        close_out;
    end
endmodule // shared_sent_slot_sample_control_tb
`default_nettype wire
